// *** rtl/phy_ctrl_cfg.svh ***
`ifndef PHY_CTRL_CFG_SVH
`define PHY_CTRL_CFG_SVH

// ---------------------------------------------------------------
// register address and reset
// ---------------------------------------------------------------
`define CTRL_REG_ADDR      5'h00
`define CTRL_REG_RESET     16'h1100

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define SPEED_LOW_POS      13
`define AUTONEG_POS        12
`define POWER_DOWN_POS     11
`define ISOLATE_POS        10
`define DUPLEX_POS         8
`define COLL_TEST_POS      7
`define SPEED_HIGH_POS     6
`define ONE_WAY_POS        5

// ---------------------------------------------------------------
// field reset values
// ---------------------------------------------------------------
`define AUTONEG_RESET      1'h1
`define ISOLATE_RESET      1'h0
`define DUPLEX_VALUE       1'h1

// ---------------------------------------------------------------
// reserved field positions
// ---------------------------------------------------------------
`define RSVD_BIT_POS       9
`define RSVD_LOW_MSB       4

// ---------------------------------------------------------------
// strap load timing
// ---------------------------------------------------------------
`define STRAP_LOAD_CNT     2'h1
`define STRAP_CNT_MAX      2'h3

`endif

// *** rtl/phy_ctrl_pkg.sv ***
package phy_ctrl_pkg;

    // management access request, one cycle
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [4:0]  addr;
        logic [15:0] wdata;
    } mgmt_req_t;

    // answer to a management read
    typedef struct packed {
        logic        valid;
        logic        hit;
        logic [15:0] rdata;
    } mgmt_rsp_t;

endpackage

// *** rtl/phy_basic_control_register.sv ***
`include "phy_ctrl_cfg.svh"

module phy_basic_control_register
    import phy_ctrl_pkg::*;
(
    input  wire logic      mclk,
    input  wire logic      reset,
    input  wire mgmt_req_t req,
    input  wire logic      autoneg_enable_control,
    input  wire logic      power_down_strap,
    output mgmt_rsp_t      rsp,
    output logic           core_soft_power_down,
    output logic           interface_isolate
);

    // ---------------------------------------------------------------
    // strap and autoneg synchroniser
    // ---------------------------------------------------------------
    logic strap_meta_ff;
    logic strap_sync_ff;
    logic an_meta_ff;
    logic an_sync_ff;

    always_ff @(posedge mclk) begin
        strap_meta_ff <= power_down_strap;
        strap_sync_ff <= strap_meta_ff;
        an_meta_ff    <= autoneg_enable_control;
        an_sync_ff    <= an_meta_ff;
    end

    // ---------------------------------------------------------------
    // writable state
    // ---------------------------------------------------------------
    logic      soft_power_down_bit_ff;
    logic      interface_isolate_bit_ff;
    logic      strap_load_ff;
    mgmt_rsp_t rsp_ff;
    logic      nxt_soft_power_down_bit;
    logic      nxt_interface_isolate_bit;
    logic      nxt_strap_load;
    mgmt_rsp_t nxt_rsp;
    logic      hit;
    logic [15:0] read_word;

    function automatic logic addr_hit(input logic [4:0] a);
        addr_hit = (a == `CTRL_REG_ADDR);
    endfunction

    always_comb begin
        read_word                         = 16'h0000;
        read_word[`AUTONEG_POS]           = an_sync_ff;
        read_word[`POWER_DOWN_POS]        = soft_power_down_bit_ff;
        read_word[`ISOLATE_POS]           = interface_isolate_bit_ff;
        read_word[`DUPLEX_POS]            = `DUPLEX_VALUE;
    end

    // ---------------------------------------------------------------
    // request decode and next state
    // ---------------------------------------------------------------
    always_comb begin
        hit                       = req.valid && addr_hit(req.addr);
        nxt_soft_power_down_bit   = soft_power_down_bit_ff;
        nxt_interface_isolate_bit = interface_isolate_bit_ff;
        // strap is sampled once, after the synchroniser has filled
        if (strap_load_ff) begin
            nxt_soft_power_down_bit = strap_sync_ff;
        end
        // writes honoured regardless of power-down
        if (hit && req.write) begin
            nxt_soft_power_down_bit   = req.wdata[`POWER_DOWN_POS];
            nxt_interface_isolate_bit = req.wdata[`ISOLATE_POS];
        end
        nxt_rsp.valid = req.valid && !req.write;
        nxt_rsp.hit   = hit;
        nxt_rsp.rdata = hit ? read_word : 16'h0000;
    end

    // strap load counter: two cycles to fill the synchroniser
    logic [1:0] strap_cnt_ff;
    logic [1:0] nxt_strap_cnt;

    // strap read once only: later motion on the pin is ignored
    always_comb begin
        nxt_strap_cnt  = (strap_cnt_ff == `STRAP_CNT_MAX) ? strap_cnt_ff : strap_cnt_ff + 2'h1;
        nxt_strap_load = (strap_cnt_ff == `STRAP_LOAD_CNT);
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            strap_cnt_ff             <= 2'h0;
            strap_load_ff            <= 1'b0;
            soft_power_down_bit_ff   <= 1'b0;
            interface_isolate_bit_ff <= `ISOLATE_RESET;
            rsp_ff                   <= '0;
        end else begin
            strap_cnt_ff             <= nxt_strap_cnt;
            strap_load_ff            <= nxt_strap_load;
            soft_power_down_bit_ff   <= nxt_soft_power_down_bit;
            interface_isolate_bit_ff <= nxt_interface_isolate_bit;
            rsp_ff                   <= nxt_rsp;
        end
    end

    assign rsp                  = rsp_ff;
    assign core_soft_power_down = soft_power_down_bit_ff;
    assign interface_isolate    = interface_isolate_bit_ff;

    // ---------------------------------------------------------------
    // sequences
    // ---------------------------------------------------------------
    sequence s_ctrl_write;
        req.valid && req.write && req.addr == `CTRL_REG_ADDR;
    endsequence

    sequence s_other_write;
        req.valid && req.write && req.addr != `CTRL_REG_ADDR;
    endsequence

    sequence s_read_req;
        req.valid && !req.write;
    endsequence

    sequence s_hit_answer;
        rsp.valid && rsp.hit;
    endsequence

    // one load pulse, two edges after reset lifts
    sequence s_strap_pulse;
        !strap_load_ff ##1 !strap_load_ff ##1 strap_load_ff ##1 !strap_load_ff;
    endsequence

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    property p_fixed_bits;
        @(posedge mclk) disable iff (reset)
        rsp.valid && rsp.hit |-> rsp.rdata[`SPEED_LOW_POS] == 1'b0
            && rsp.rdata[`SPEED_HIGH_POS] == 1'b0 && rsp.rdata[`DUPLEX_POS] == 1'b1
            && rsp.rdata[`COLL_TEST_POS] == 1'b0 && rsp.rdata[`ONE_WAY_POS] == 1'b0;
    endproperty
    a_fixed_bits: assert property (p_fixed_bits) else $error("fixed bits wrong");

    property p_reserved_zero;
        @(posedge mclk) disable iff (reset)
        rsp.valid |-> rsp.rdata[`RSVD_BIT_POS] == 1'b0 && rsp.rdata[`RSVD_LOW_MSB:0] == 5'h00;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved nonzero");

    property p_write_pd;
        @(posedge mclk) disable iff (reset)
        // a write on the strap load edge must win over the strap
        s_ctrl_write |=> core_soft_power_down == $past(req.wdata[`POWER_DOWN_POS]);
    endproperty
    a_write_pd: assert property (p_write_pd) else $error("power-down write lost");

    property p_write_iso;
        @(posedge mclk) disable iff (reset)
        req.valid && req.write && req.addr == `CTRL_REG_ADDR
            |=> interface_isolate == $past(req.wdata[`ISOLATE_POS]);
    endproperty
    a_write_iso: assert property (p_write_iso) else $error("isolate write lost");

    property p_read_answer;
        @(posedge mclk) disable iff (reset)
        req.valid && !req.write |=> rsp.valid;
    endproperty
    a_read_answer: assert property (p_read_answer) else $error("read unanswered");

    property p_an_mirror;
        @(posedge mclk) disable iff (reset)
        rsp.valid && rsp.hit |-> rsp.rdata[`AUTONEG_POS] == $past(an_sync_ff);
    endproperty
    a_an_mirror: assert property (p_an_mirror) else $error("autoneg mirror wrong");

    property p_strap;
        @(posedge mclk) disable iff (reset)
        strap_load_ff && !(req.valid && req.write) |=> core_soft_power_down == $past(strap_sync_ff);
    endproperty
    a_strap: assert property (p_strap) else $error("strap not loaded");

    property p_iso_reset;
        @(posedge mclk) $fell(reset) |-> interface_isolate == 1'b0 && !rsp.valid;
    endproperty
    a_iso_reset: assert property (p_iso_reset) else $error("isolate reset wrong");

    property p_miss_read;
        @(posedge mclk) disable iff (reset)
        rsp.valid && !rsp.hit |-> rsp.rdata == 16'h0000;
    endproperty
    a_miss_read: assert property (p_miss_read) else $error("miss read not zero");

    property p_miss_write;
        @(posedge mclk) disable iff (reset)
        s_other_write ##0 !strap_load_ff
            |=> $stable(core_soft_power_down) && $stable(interface_isolate);
    endproperty
    a_miss_write: assert property (p_miss_write) else $error("miss write took effect");

    property p_read_hit;
        @(posedge mclk) disable iff (reset)
        s_read_req ##0 req.addr == `CTRL_REG_ADDR |=> s_hit_answer;
    endproperty
    a_read_hit: assert property (p_read_hit) else $error("control read missed");

    property p_write_silent;
        @(posedge mclk) disable iff (reset)
        req.valid && req.write |=> !rsp.valid;
    endproperty
    a_write_silent: assert property (p_write_silent) else $error("write answered");

    property p_read_word;
        @(posedge mclk) disable iff (reset)
        s_hit_answer |-> rsp.rdata[`POWER_DOWN_POS] == $past(core_soft_power_down)
            && rsp.rdata[`ISOLATE_POS] == $past(interface_isolate);
    endproperty
    a_read_word: assert property (p_read_word) else $error("control bits misread");

    property p_strap_pulse;
        @(posedge mclk) disable iff (reset)
        $fell(reset) |-> s_strap_pulse;
    endproperty
    a_strap_pulse: assert property (p_strap_pulse) else $error("strap load mistimed");

endmodule // phy_basic_control_register

// *** verif/mgmt_host_model.sv ***
module mgmt_host_model
    import phy_ctrl_pkg::*;
(
    input  wire logic      mclk,
    output mgmt_req_t      req,
    input  wire mgmt_rsp_t rsp
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------
    // one-cycle strobe per access
    // ------------------------------
    initial req = '0;
    // released fields show the inverse, not a stale copy
    task automatic xfer(input logic w, input logic [4:0] a, input logic [15:0] d,
                        output mgmt_rsp_t r);
        @(posedge mclk);
        #1;
        req = '{valid: 1'b1, write: w, addr: a, wdata: d};
        @(posedge mclk);
        #1;
        r = rsp;
        req = '{valid: 1'b0, write: ~w, addr: ~a, wdata: ~d};
    endtask
endmodule // mgmt_host_model

// *** verif/tb_top.sv ***
module tb_top;
    import phy_ctrl_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic      mclk = 1'b0;
    logic      reset = 1'b1;
    logic      an_ctl = 1'b1;
    logic      strap = 1'b1;
    mgmt_req_t req;
    mgmt_rsp_t rsp;
    logic      pd;
    logic      iso;
    int        error_cnt = 0;
    int        checked = 0;
    int        cycles = 0;
    always #2 mclk = ~mclk;
    mgmt_host_model host_u (.mclk(mclk), .req(req), .rsp(rsp));
    phy_basic_control_register dut_u (
        .mclk                  (mclk),
        .reset                 (reset),
        .req                   (req),
        .autoneg_enable_control(an_ctl),
        .power_down_strap      (strap),
        .rsp                   (rsp),
        .core_soft_power_down  (pd),
        .interface_isolate     (iso)
    );
    // ------------------------------
    // access and compare tasks
    // ------------------------------
    task automatic final_report();
        $display("checks=%0d errors=%0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [17:0] got, input logic [17:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [4:0] a, input logic [17:0] exp);
        mgmt_rsp_t r;
        host_u.xfer(1'b0, a, 16'h0000, r);
        chk({r.valid, r.hit, r.rdata}, exp);
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        mgmt_rsp_t r;
        host_u.xfer(1'b1, a, d, r);
    endtask
    task automatic do_reset(input logic s);
        reset = 1'b1;
        strap = s;
        repeat (5) @(posedge mclk);
        #1;
        reset = 1'b0;
        repeat (4) @(posedge mclk);
        #1;
    endtask
    // hang guard, a full run is about 41 cycles
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 2000) begin
            error_cnt++;
            final_report();
        end
    end
    initial begin
        do_reset(1'b1);
        chk({16'h0000, pd, iso}, 18'h00002);
        rd(5'h00, 18'h31900);
        wr(5'h00, 16'hffff);
        rd(5'h00, 18'h31d00);
        chk({16'h0000, pd, iso}, 18'h00003);
        an_ctl = 1'b0;
        repeat (3) @(posedge mclk);
        #1;
        rd(5'h00, 18'h30d00);
        wr(5'h00, 16'h0000);
        rd(5'h00, 18'h30100);
        chk({16'h0000, pd, iso}, 18'h00000);
        wr(5'h01, 16'hffff);
        rd(5'h00, 18'h30100);
        rd(5'h01, 18'h20000);
        an_ctl = 1'b1;
        do_reset(1'b0);
        rd(5'h00, 18'h31100);
        chk({16'h0000, pd, iso}, 18'h00000);
        final_report();
    end
endmodule // tb_top
